// File: rtl/stm_defines.svh
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

`define STM_CNT_W          16
`define STM_P_W            8
`define STM_P_SHIFT        8

// APB byte addresses
`define STM_ADDR_W         5
`define STM_OFF_CTRL0      5'h00
`define STM_OFF_CTRL1      5'h04
`define STM_OFF_COUNT      5'h08
`define STM_OFF_CMPA       5'h0C
`define STM_OFF_CMPP       5'h10
`define STM_OFF_FLAGS      5'h14

// Control 0 field positions
`define STM_RUN_BIT        0
`define STM_CKSEL_BIT      1
// Flag register positions
`define STM_FLAG_A_BIT     0
`define STM_FLAG_P_BIT     1

// Reset values
`define STM_CTRL1_RST      8'h00
`define STM_CMPA_RST       16'h0000
`define STM_CMPP_RST       8'h00

// Mode field codes
`define STM_MODE_CMO       2'h0
`define STM_MODE_CAP       2'h1
`define STM_MODE_PWM       2'h2
`define STM_MODE_TC        2'h3

// Pin function codes
`define STM_PF_00          2'h0
`define STM_PF_01          2'h1
`define STM_PF_10          2'h2
`define STM_PF_11          2'h3

`endif

// File: rtl/stm_pkg.sv
`include "stm_defines.svh"
package stm_pkg;

    typedef enum logic [1:0] {
        STM_CMO = `STM_MODE_CMO,
        STM_CAP = `STM_MODE_CAP,
        STM_PWM = `STM_MODE_PWM,
        STM_TC  = `STM_MODE_TC
    } stm_mode_type;

    // Control 1 layout, msb first
    typedef struct packed {
        stm_mode_type mode;
        logic [1:0]   pin_function;
        logic         output_control_level;
        logic         output_polarity_invert;
        logic         duty_period_swap;
        logic         clear_condition_select;
    } stm_ctrl_type;

    // Per-tick counter events
    typedef struct packed {
        logic a_hit;
        logic p_hit;
        logic clear;
        logic a_set;
        logic p_set;
    } stm_evt_type;

endpackage

// File: rtl/stm_timer.sv
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.svh"
module stm_timer
    import stm_pkg::*;
#(
    parameter int CNT_W = `STM_CNT_W,
    parameter int P_W   = `STM_P_W
)
(
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [`STM_ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]            pwdata_in,
    output logic      [31:0]            prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    input  wire logic                   external_clock_pin_in,
    input  wire logic                   capture_input_pin_in,
    output logic                        timer_out_out,
    output logic                        timer_out_en_out
);

    generate
        if (CNT_W != P_W + `STM_P_SHIFT)
        begin : g_bad_width
            $error("stm_timer: CNT_W must equal P_W plus 8");
        end
    endgenerate

    localparam int NPIN = 2;

    // Pin synchronisers: stage 0 and 1 are the pair, stage 2 is edge history
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync0_r;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    logic [NPIN-1:0] pin_rise;
    logic [NPIN-1:0] pin_fall;

    assign pin_raw = {capture_input_pin_in, external_clock_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_ff @(posedge ref_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    sync0_r[gi] <= 1'b0;
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end
                else
                begin
                    sync0_r[gi] <= pin_raw[gi];
                    sync1_r[gi] <= sync0_r[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
            // Edges shorter than one clock can be lost here
            assign pin_rise[gi] = sync1_r[gi] & ~sync2_r[gi];
            assign pin_fall[gi] = ~sync1_r[gi] & sync2_r[gi];
        end
    endgenerate

    // Registers
    stm_ctrl_type          ctrl_r;
    logic                  run_r;
    logic                  cksel_r;
    logic [CNT_W-1:0]      count_r;
    logic [CNT_W-1:0]      cmpa_r;
    logic [P_W-1:0]        cmpp_r;
    logic                  flag_a_r;
    logic                  flag_p_r;
    logic                  cap_pend_r;
    logic                  cmo_lvl_r;

    // APB decode
    logic                  apb_done;
    logic                  wr_en;
    logic                  addr_ok;
    logic [31:0]           rd_mux;

    assign apb_done = psel_in & penable_in & pready_out;
    assign wr_en    = apb_done & pwrite_in & addr_ok;

    always_comb
    begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr_in)
            `STM_OFF_CTRL0:
            begin
                rd_mux[`STM_RUN_BIT]   = run_r;
                rd_mux[`STM_CKSEL_BIT] = cksel_r;
            end
            `STM_OFF_CTRL1: rd_mux[$bits(stm_ctrl_type)-1:0] = ctrl_r;
            `STM_OFF_COUNT: rd_mux[CNT_W-1:0] = count_r;
            `STM_OFF_CMPA:  rd_mux[CNT_W-1:0] = cmpa_r;
            `STM_OFF_CMPP:  rd_mux[P_W-1:0]   = cmpp_r;
            `STM_OFF_FLAGS:
            begin
                rd_mux[`STM_FLAG_A_BIT] = flag_a_r;
                rd_mux[`STM_FLAG_P_BIT] = flag_p_r;
            end
            default: addr_ok = 1'b0;
        endcase
    end

    // One wait state: ready rises on the second access cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out  <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
            if (psel_in & penable_in & ~pready_out & ~pwrite_in)
            begin
                prdata_out <= rd_mux;
            end
        end
    end

    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_cmpa;
    logic wr_cmpp;
    logic wr_flags;

    assign wr_ctrl0 = wr_en & (paddr_in == `STM_OFF_CTRL0);
    assign wr_ctrl1 = wr_en & (paddr_in == `STM_OFF_CTRL1);
    assign wr_cmpa  = wr_en & (paddr_in == `STM_OFF_CMPA);
    assign wr_cmpp  = wr_en & (paddr_in == `STM_OFF_CMPP);
    assign wr_flags = wr_en & (paddr_in == `STM_OFF_FLAGS);

    // Mode decode
    logic is_pulse;
    logic is_pwm;
    logic is_cap;
    logic is_cmp;

    assign is_pulse = (ctrl_r.mode == STM_PWM) & (ctrl_r.pin_function == `STM_PF_11);
    assign is_pwm   = (ctrl_r.mode == STM_PWM) & ~is_pulse;
    assign is_cap   = (ctrl_r.mode == STM_CAP);
    assign is_cmp   = (ctrl_r.mode == STM_CMO) | (ctrl_r.mode == STM_TC);

    // Timer tick: every clock, or synchronised rising edge of the clock pin
    logic tick;
    logic tick_run;
    assign tick     = cksel_r ? pin_rise[0] : 1'b1;
    assign tick_run = tick & run_r;

    // Next count and compares
    logic [CNT_W:0]   nxt;
    logic             ovf;
    logic             p_raw;
    stm_evt_type      evt;

    assign nxt   = {1'b0, count_r} + {{CNT_W{1'b0}}, 1'b1};
    assign ovf   = nxt[CNT_W];
    assign p_raw = (nxt[CNT_W-1:`STM_P_SHIFT] == cmpp_r)
                 & (nxt[`STM_P_SHIFT-1:0] == '0);

    always_comb
    begin
        evt       = '0;
        evt.a_hit = (nxt[CNT_W-1:0] == cmpa_r) & (cmpa_r != '0);
        evt.p_hit = (cmpp_r == '0) ? ovf : p_raw;
        if (is_cmp)
        begin
            evt.clear = ctrl_r.clear_condition_select ? evt.a_hit : evt.p_hit;
            evt.a_set = evt.a_hit;
            evt.p_set = evt.p_hit & ~ctrl_r.clear_condition_select;
        end
        else if (is_pwm)
        begin
            evt.clear = ctrl_r.duty_period_swap ? evt.a_hit : evt.p_hit;
            evt.a_set = evt.a_hit;
            evt.p_set = evt.p_hit;
        end
        else if (is_pulse)
        begin
            evt.a_set = evt.a_hit;
        end
        else
        begin
            evt.clear = evt.p_hit;
            evt.p_set = evt.p_hit;
        end
    end

    // Run bit and its rising edge
    logic sp_trig;
    logic run_set_evt;
    logic run_nxt;

    assign sp_trig     = is_pulse & pin_rise[0] & ~run_r;
    assign run_set_evt = ~run_r & ((wr_ctrl0 & pwdata_in[`STM_RUN_BIT]) | sp_trig);

    always_comb
    begin
        run_nxt = run_r;
        if (is_pulse & tick_run & evt.a_hit)
        begin
            run_nxt = 1'b0;
        end
        if (sp_trig)
        begin
            run_nxt = 1'b1;
        end
        if (wr_ctrl0)
        begin
            run_nxt = pwdata_in[`STM_RUN_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            run_r   <= 1'b0;
            cksel_r <= 1'b0;
        end
        else
        begin
            run_r <= run_nxt;
            if (wr_ctrl0)
            begin
                cksel_r <= pwdata_in[`STM_CKSEL_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_r <= stm_ctrl_type'(`STM_CTRL1_RST);
            cmpp_r <= `STM_CMPP_RST;
        end
        else
        begin
            if (wr_ctrl1)
            begin
                ctrl_r <= stm_ctrl_type'(pwdata_in[$bits(stm_ctrl_type)-1:0]);
            end
            if (wr_cmpp)
            begin
                cmpp_r <= pwdata_in[P_W-1:0];
            end
        end
    end

    // Counter
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_r <= '0;
        end
        else if (run_set_evt)
        begin
            count_r <= '0;
        end
        else if (tick_run)
        begin
            count_r <= evt.clear ? '0 : nxt[CNT_W-1:0];
        end
    end

    // Capture edge select
    logic cap_evt;
    always_comb
    begin
        case (ctrl_r.pin_function)
            `STM_PF_00: cap_evt = pin_rise[1];
            `STM_PF_01: cap_evt = pin_fall[1];
            `STM_PF_10: cap_evt = pin_rise[1] | pin_fall[1];
            default:    cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt & is_cap;
    end

    // Capture beats a software write to the A value
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cmpa_r     <= `STM_CMPA_RST;
            cap_pend_r <= 1'b0;
        end
        else
        begin
            cap_pend_r <= cap_evt;
            if (cap_evt)
            begin
                cmpa_r <= count_r;
            end
            else if (wr_cmpa)
            begin
                cmpa_r <= pwdata_in[CNT_W-1:0];
            end
        end
    end

    // Flags: write one to clear, a same-cycle set wins
    logic set_a;
    logic set_p;
    assign set_a = (tick_run & evt.a_set) | cap_pend_r;
    assign set_p = tick_run & evt.p_set;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            flag_a_r <= 1'b0;
            flag_p_r <= 1'b0;
        end
        else
        begin
            if (set_a)
            begin
                flag_a_r <= 1'b1;
            end
            else if (wr_flags & pwdata_in[`STM_FLAG_A_BIT])
            begin
                flag_a_r <= 1'b0;
            end
            if (set_p)
            begin
                flag_p_r <= 1'b1;
            end
            else if (wr_flags & pwdata_in[`STM_FLAG_P_BIT])
            begin
                flag_p_r <= 1'b0;
            end
        end
    end

    // Compare-match output level, set to initial level at run rise
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cmo_lvl_r <= 1'b0;
        end
        else if (run_set_evt)
        begin
            cmo_lvl_r <= ctrl_r.output_control_level;
        end
        else if (tick_run & evt.a_set)
        begin
            case (ctrl_r.pin_function)
                `STM_PF_01: cmo_lvl_r <= 1'b0;
                `STM_PF_10: cmo_lvl_r <= 1'b1;
                `STM_PF_11: cmo_lvl_r <= ~cmo_lvl_r;
                default:    cmo_lvl_r <= cmo_lvl_r;
            endcase
        end
    end

    // PWM duty, widened so a P of zero means 65536
    logic [CNT_W:0] duty;
    logic           pwm_act;
    logic           lvl;
    logic           drive;

    always_comb
    begin
        if (ctrl_r.duty_period_swap)
        begin
            duty = (cmpp_r == '0) ? {1'b1, {CNT_W{1'b0}}}
                                  : {1'b0, cmpp_r, {`STM_P_SHIFT{1'b0}}};
        end
        else
        begin
            duty = {1'b0, cmpa_r};
        end
    end

    // Count never reaches the period, so duty at or past it stays active
    assign pwm_act = ({1'b0, count_r} < duty);

    always_comb
    begin
        lvl   = 1'b0;
        drive = 1'b0;
        if (ctrl_r.mode == STM_CMO)
        begin
            drive = 1'b1;
            lvl   = cmo_lvl_r;
        end
        else if (is_pulse)
        begin
            drive = 1'b1;
            lvl   = run_r ~^ ctrl_r.output_control_level;
        end
        else if (is_pwm)
        begin
            drive = 1'b1;
            case (ctrl_r.pin_function)
                `STM_PF_00: lvl = ~ctrl_r.output_control_level;
                `STM_PF_01: lvl = ctrl_r.output_control_level;
                default:    lvl = pwm_act ~^ ctrl_r.output_control_level;
            endcase
        end
        // Capture and timer modes leave the pin to other functions
        lvl = drive & (lvl ^ ctrl_r.output_polarity_invert);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            timer_out_out    <= 1'b0;
            timer_out_en_out <= 1'b0;
        end
        else
        begin
            timer_out_out    <= lvl;
            timer_out_en_out <= drive;
        end
    end

endmodule // stm_timer
`default_nettype wire

// File: testbench/stm_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module stm_pin_partner
(
    input  wire logic ref_clk_in,
    input  wire logic timer_out_in,
    input  wire logic timer_out_en_in,
    output var logic  ext_pin_out,
    output var logic  cap_pin_out,
    output var int    hi_cnt_out
);
    initial
    begin
        ext_pin_out = 1'b0;
        cap_pin_out = 1'b0;
        hi_cnt_out = 0;
    end

    // Load has a pull-down, so an undriven pin counts as low
    always @(posedge ref_clk_in)
        if (timer_out_en_in && timer_out_in)
            hi_cnt_out <= hi_cnt_out + 1;

    // Held four clocks, safely above the shortest pulse seen
    task automatic ext_pulse();
        @(posedge ref_clk_in);
        ext_pin_out <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        ext_pin_out <= 1'b0;
    endtask

    task automatic cap_wave(input int hi);
        @(posedge ref_clk_in);
        cap_pin_out <= 1'b1;
        repeat (hi) @(posedge ref_clk_in);
        cap_pin_out <= 1'b0;
    endtask
endmodule  // stm_pin_partner
`default_nettype wire

// File: testbench/stm_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.svh"
module stm_timer_properties
    import stm_pkg::*;
(
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [4:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        external_clock_pin_in,
    input wire logic        capture_input_pin_in,
    input wire logic        timer_out_out,
    input wire logic        timer_out_en_out
);
    stm_ctrl_type ctl_r;
    logic [1:0]   age_r;

    // Shadow of control 1; age hides the pin latency after a write
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctl_r <= '0;
            age_r <= 2'h0;
        end
        else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == `STM_OFF_CTRL1)
        begin
            ctl_r <= stm_ctrl_type'(pwdata_in[7:0]);
            age_r <= 2'h0;
        end
        else if (age_r != 2'h3)
            age_r <= age_r + 2'h1;
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_ready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("pready late");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready held");
    a_ready_cause: assert property (pready_out |-> psel_in && penable_in && $past(penable_in))
        else $error("pready without access");
    a_err_ready: assert property (pslverr_out |-> pready_out && (pwrite_in || prdata_out == 32'h0))
        else $error("pslverr alone or read not zero");
    a_err_map: assert property (pready_out && paddr_in[1:0] == 2'h0
        |-> pslverr_out == (paddr_in > `STM_OFF_FLAGS))
        else $error("pslverr wrong for address");
    a_tc_quiet: assert property (age_r == 2'h3 && ctl_r.mode == STM_TC |-> !timer_out_en_out)
        else $error("pin driven in timer mode");
    a_cap_quiet: assert property (age_r == 2'h3 && ctl_r.mode == STM_CAP |-> !timer_out_en_out)
        else $error("pin driven in capture mode");
    a_pwm_drive: assert property (age_r == 2'h3 && ctl_r.mode == STM_PWM |-> timer_out_en_out)
        else $error("pin not driven in pwm mode");
    a_forced_level: assert property (age_r == 2'h3 && ctl_r.mode == STM_PWM
        && !ctl_r.pin_function[1] |-> timer_out_out == ((ctl_r.pin_function[0]
        ~^ ctl_r.output_control_level) ^ ctl_r.output_polarity_invert))
        else $error("forced level wrong");
    a_idle_low: assert property (!timer_out_en_out |-> !timer_out_out)
        else $error("undriven pin not low");
endmodule  // stm_timer_properties

bind stm_timer stm_timer_properties stm_timer_properties_i (.ref_clk_in, .rst_n_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .external_clock_pin_in, .capture_input_pin_in, .timer_out_out, .timer_out_en_out);
`default_nettype wire

// File: testbench/stm_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.svh"
module stm_timer_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [4:0]  padr = 5'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic        rdy, err, xpin, cpin, tout, ten;
    int          hi, tcyc, num_errors = 0, n_checks = 0, cyc = 0;
    logic [7:0]  pc [7] = '{8'hA9, 8'hA1, 8'hAD, 8'hAB, 8'hA9, 8'h89, 8'h99};
    int          pa [7] = '{'h40, 'h40, 'h40, 'h300, 'h200, 'h40, 'h40};
    int          pw [7] = '{512, 512, 512, 768, 256, 512, 512};

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    stm_timer stm_timer_i (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
        .pslverr_out(err), .external_clock_pin_in(xpin), .capture_input_pin_in(cpin),
        .timer_out_out(tout), .timer_out_en_out(ten));
    stm_pin_partner stm_pin_partner_i (.ref_clk_in(clk), .timer_out_in(tout),
        .timer_out_en_in(ten), .ext_pin_out(xpin), .cap_pin_out(cpin), .hi_cnt_out(hi));

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s exp %0h got %0h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (rdy !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            chk("pready", 32'h1, 32'h0);
            close_out();
        end
        r = prd;
        e = err;
        tcyc = cyc;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // Stop first: pin function must not change while running
    task automatic setup(input logic [31:0] c, input logic [31:0] a, input logic [31:0] p,
        input logic go);
        wr(`STM_OFF_CTRL0, 32'h0);
        wr(`STM_OFF_CMPA, a);
        wr(`STM_OFF_CMPP, p);
        wr(`STM_OFF_CTRL1, c);
        if (go)
            wr(`STM_OFF_CTRL0, 32'h1);
    endtask

    task automatic run_case(input logic [31:0] c, input logic [31:0] a, input logic [31:0] ef,
        input logic [31:0] lim);
        logic [31:0] r;
        setup(c, a, 32'h1, 1'b1);
        wr(`STM_OFF_FLAGS, 32'h3);
        repeat (300) @(posedge clk);
        rd(`STM_OFF_FLAGS, r);
        chk("flags", ef, r);
        rd(`STM_OFF_COUNT, r);
        chk("count range", 32'h1, {31'h0, r < lim});
    endtask

    // Reference model of pwm high time and flags over a window
    function automatic int pwm_hi(input logic [7:0] c, input int a, input int p, input int w,
        output int fl);
        int per, dut, act;
        per = c[1] ? a : (p == 0 ? 65536 : p * 256);
        dut = c[1] ? (p == 0 ? 65536 : p * 256) : a;
        act = dut >= per ? per : dut;
        if (c[5:4] == 2'h0)
            act = 0;
        if (c[5:4] == 2'h1)
            act = per;
        fl = c[1] ? (1 + (p != 0 && p * 256 < a ? 2 : 0)) : (2 + (a != 0 && a < per ? 1 : 0));
        return (w / per) * ((c[3] ^ c[2]) ? act : per - act);
    endfunction

    initial
    begin
        logic [31:0] r, a1, a2, d;
        logic        e, ok;
        int          h0, t1, fl, ex;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        void'($urandom(1714));
        for (int k = 0; k < 6; k++)
        begin
            rd(5'(k * 4), r);
            chk("reset value", 32'h0, r);
        end
        apb(1'b0, 5'h18, 32'h0, r, e);
        chk("unmapped", 32'h1, {31'h0, e});
        apb(1'b1, 5'h1C, 32'hFFFF_FFFF, r, e);
        chk("unmapped write", 32'h1, {31'h0, e});
        wr(`STM_OFF_COUNT, 32'h1234);
        rd(`STM_OFF_COUNT, r);
        chk("count read only", 32'h0, r);
        d = $urandom;
        wr(`STM_OFF_CMPA, d);
        wr(`STM_OFF_CMPP, d);
        wr(`STM_OFF_CTRL1, d);
        rd(`STM_OFF_CMPA, r);
        chk("cmpa", d & 32'hFFFF, r);
        rd(`STM_OFF_CMPP, r);
        chk("cmpp", d & 32'hFF, r);
        rd(`STM_OFF_CTRL1, r);
        chk("ctrl1", d & 32'hFF, r);
        $display("test registers done");
        setup(32'hC0, 32'h0, 32'h0, 1'b1);
        rd(`STM_OFF_COUNT, a1);
        t1 = tcyc;
        rd(`STM_OFF_COUNT, a2);
        chk("count rate", 32'(tcyc - t1), (a2 - a1) & 32'hFFFF);
        wr(`STM_OFF_CTRL0, 32'h0);
        rd(`STM_OFF_COUNT, a1);
        repeat (10) @(posedge clk);
        rd(`STM_OFF_COUNT, a2);
        chk("count hold", a1, a2);
        // Ticks from the clock pin; gaps kept above the shortest pulse
        setup(32'hC0, 32'h0, 32'h0, 1'b0);
        wr(`STM_OFF_CTRL0, 32'h3);
        rd(`STM_OFF_COUNT, a1);
        ex = 3 + int'($urandom % 7);
        repeat (ex)
        begin
            stm_pin_partner_i.ext_pulse();
            repeat (2) @(posedge clk);
        end
        rd(`STM_OFF_COUNT, a2);
        chk("pin ticks", 32'(ex), a2 - a1);
        run_case(32'hC0, 32'h0, 32'h2, 32'h100);
        run_case(32'hC1, 32'h20, 32'h1, 32'h20);
        $display("test timer done");
        for (int i = 0; i < 7; i++)
        begin
            setup(32'(pc[i]), 32'(pa[i]), 32'h1, 1'b1);
            repeat (20) @(posedge clk);
            wr(`STM_OFF_FLAGS, 32'h3);
            h0 = hi;
            ex = pwm_hi(pc[i], pa[i], 1, pw[i], fl);
            repeat (pw[i]) @(posedge clk);
            chk("pwm high", 32'(ex), 32'(hi - h0));
            rd(`STM_OFF_FLAGS, r);
            chk("pwm flags", 32'(fl), r);
        end
        $display("test pwm done");
        for (int i = 0; i < 2; i++)
        begin
            setup(32'hBB, 32'h30, 32'h1, 1'b0);
            wr(`STM_OFF_FLAGS, 32'h3);
            h0 = hi;
            if (i == 0)
                wr(`STM_OFF_CTRL0, 32'h1);
            else
                stm_pin_partner_i.ext_pulse();
            repeat (150) @(posedge clk);
            chk("pulse width", 32'h30, 32'(hi - h0));
            rd(`STM_OFF_CTRL0, r);
            chk("run cleared", 32'h0, r & 32'h1);
            rd(`STM_OFF_FLAGS, r);
            chk("pulse flags", 32'h1, r);
        end
        $display("test single pulse done");
        for (int i = 0; i < 4; i++)
        begin
            setup(32'h40 | 32'(i << 4), 32'h0, 32'h0, 1'b1);
            wr(`STM_OFF_FLAGS, 32'h3);
            fork
                stm_pin_partner_i.cap_wave(60);
                begin
                    repeat (20) @(posedge clk);
                    rd(`STM_OFF_CMPA, a1);
                end
            join
            repeat (20) @(posedge clk);
            rd(`STM_OFF_CMPA, a2);
            rd(`STM_OFF_FLAGS, r);
            chk("capture flag", i == 3 ? 32'h0 : 32'h1, r);
            case (i)
                0: ok = a1 != 0 && a2 == a1;
                1: ok = a1 == 0 && a2 != 0;
                2: ok = ((a2 - a1) & 32'hFFFF) == 60;
                default: ok = (a1 | a2) == 0;
            endcase
            chk("capture value", 32'h1, {31'h0, ok});
        end
        run_case(32'h77, 32'h0, 32'h2, 32'h100);
        $display("test capture done");
        close_out();
    end
endmodule  // stm_timer_tb_top
`default_nettype wire
